// ===== dv/two_wire_master_engine_chk.sv
`timescale 1ns/10ps
`default_nettype none
module two_wire_master_engine_chk (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // time base and registers
    input wire logic        bus_clock_ref,
    input wire logic [15:0] sfr_addr,
    input wire logic        sfr_write,
    input wire logic [7:0]  sfr_wdata,
    input wire logic [7:0]  sfr_rdata,
    // interrupt and bus
    input wire logic        ext_irq6,
    input wire logic        scl_out,
    input wire logic        scl_oe,
    input wire logic        sda_out,
    input wire logic        sda_oe
);
    logic en_q;
    always_ff @(posedge clk)
    begin
        if (rst)
            en_q <= 1'b0;
        else if (sfr_write && sfr_addr == 16'hff95)
            en_q <= sfr_wdata[3];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_launch;
        sfr_write && sfr_addr == 16'hff85 && sfr_wdata[1];
    endsequence
    sequence s_stop;
        $fell(sda_oe) && !scl_oe;
    endsequence
    property p_open_drain;
        !scl_out && !sda_out;
    endproperty
    property p_scl_low_on_ref;
        $rose(scl_oe) |-> !bus_clock_ref;
    endproperty
    property p_sda_on_ref_low;
        $changed(sda_oe) |-> !bus_clock_ref;
    endproperty
    property p_scl_high_time;
        $fell(scl_oe) |=> !scl_oe [*8];
    endproperty
    property p_irq_gate;
        ext_irq6 |-> $past(en_q);
    endproperty
    property p_irq_on_stop;
        s_stop ##0 en_q |=> ext_irq6;
    endproperty
    property p_irq_clear;
        s_launch ##0 ext_irq6 |-> ##2 !ext_irq6;
    endproperty
    property p_unmapped;
        sfr_addr[15:8] != 8'hff |=> sfr_rdata == 8'h00;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");
    a_scl_low_on_ref: assert property (p_scl_low_on_ref) else $error("scl off ref");
    a_sda_on_ref_low: assert property (p_sda_on_ref_low) else $error("sda moved");
    a_scl_high_time: assert property (p_scl_high_time) else $error("scl short");
    a_irq_gate: assert property (p_irq_gate) else $error("irq unmasked");
    a_irq_on_stop: assert property (p_irq_on_stop) else $error("no irq at end");
    a_irq_clear: assert property (p_irq_clear) else $error("irq held");
    a_unmapped: assert property (p_unmapped) else $error("unmapped data");
endmodule
bind two_wire_master_engine two_wire_master_engine_chk i_chk (
    .clk, .rst, .bus_clock_ref, .sfr_addr, .sfr_write, .sfr_wdata, .sfr_rdata,
    .ext_irq6, .scl_out, .scl_oe, .sda_out, .sda_oe
);
`default_nettype wire

// ===== dv/two_wire_master_engine_tb.sv
`timescale 1ns/10ps
`default_nettype none
module two_wire_master_engine_tb;
    logic        clk;
    logic        rst;
    logic        bus_clock_ref;
    logic [15:0] sfr_addr;
    logic        sfr_write;
    logic [7:0]  sfr_wdata;
    logic        nak;
    wire  [7:0]  sfr_rdata;
    wire         ext_irq6;
    wire         scl_oe;
    wire         sda_oe;
    wire         pull;
    wire         scl = !scl_oe;
    wire         sda = !(sda_oe || pull);
    int          n_errors;
    int          num_checks;
    two_wire_master_engine i_dut (.clk(clk), .rst(rst), .bus_clock_ref(bus_clock_ref),
        .sfr_addr(sfr_addr), .sfr_write(sfr_write), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .ext_irq6(ext_irq6), .scl_in(scl), .scl_out(),
        .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe));
    two_wire_slave_model i_slave (.scl(scl), .sda(sda), .nak(nak), .pull(pull));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always #1250 bus_clock_ref = ~bus_clock_ref;
    task chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_write = 1'b1;
        @(posedge clk) #1;
        sfr_write = 1'b0;
    endtask
    task rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk) #1;
        sfr_addr = a;
        @(posedge clk) #1;
        d = sfr_rdata;
    endtask
    task rchk(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d, e);
    endtask
    // launch, then poll busy; the poll bound cuts a stuck engine short
    task run(input logic [7:0] transfer_control_status, input logic en);
        logic [7:0] d;
        wr(16'hff85, transfer_control_status);
        rd(16'hff85, d);
        chk(d & 8'h02, 8'h02);
        chk({7'h0, ext_irq6}, 8'h00);
        for (int i = 0; i < 20000 && d[1] !== 1'b0; i++)
            rd(16'hff85, d);
        chk(d & 8'h02, 8'h00);
        @(posedge clk) #1;
        chk({7'h0, ext_irq6}, {7'h0, en});
    endtask
    task t_reset;
        for (int i = 0; i < 6; i++)
            rchk(16'hff80 + 16'(i), 8'h00);
        rchk(16'hff95, 8'h00);
        wr(16'h1234, 8'hff);
        rchk(16'h1234, 8'h00);
    endtask
    task t_write;
        wr(16'hff95, 8'h08);
        wr(16'hff80, 8'h54);
        wr(16'hff81, 8'h96);
        wr(16'hff82, 8'h0f);
        rchk(16'hff80, 8'h54);
        run(8'h03, 1'b1);
        chk(i_slave.got[0], 8'h54);
        chk(i_slave.got[1], 8'h96);
        chk(i_slave.got[2], 8'h0f);
        rchk(16'hff85, 8'h01);
        rchk(16'hff95, 8'h0c);
    endtask
    task t_nak;
        nak = 1'b1;
        wr(16'hff95, 8'h00);
        run(8'h02, 1'b0);
        rchk(16'hff85, 8'h04);
        rchk(16'hff95, 8'h04);
        nak = 1'b0;
    endtask
    task t_read;
        wr(16'hff80, 8'h55);
        run(8'h02, 1'b0);
        rchk(16'hff85, 8'h00);
        rchk(16'hff83, 8'ha5);
        rchk(16'hff84, 8'h00);
        wr(16'hff95, 8'h08);
        run(8'h03, 1'b1);
        rchk(16'hff83, 8'ha5);
        rchk(16'hff84, 8'h3c);
    endtask
    task stop_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #600_000;
        n_errors++;
        stop_test;
    end
    initial
    begin
        rst = 1'b1;
        bus_clock_ref = 1'b0;
        sfr_addr = 16'h0000;
        sfr_write = 1'b0;
        sfr_wdata = 8'h00;
        nak = 1'b0;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        t_reset;
        t_write;
        t_nak;
        t_read;
        stop_test;
    end
endmodule
`default_nettype wire

// ===== dv/two_wire_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module two_wire_slave_model #(
    parameter logic [6:0]  ADDR  = 7'h2a,
    parameter logic [15:0] RDATA = 16'ha53c
) (
    // bus levels
    input  wire logic scl,
    input  wire logic sda,
    // refuse the address
    input  wire logic nak,
    // high pulls sda low
    output logic      pull
);
    logic [7:0] rx;
    logic [7:0] got [3];
    logic       rd;
    int         n;
    int         k;
    initial pull = 1'b0;
    // scl and sda can move in one time step; a start needs scl still high after it
    always @(negedge sda)
    begin
        #1;
        if (scl === 1'b1)
        begin
            n = 0;
            k = 0;
            rd = 1'b0;
        end
    end
    always @(posedge scl)
    begin
        rx = {rx[6:0], sda};
        n = n + 1;
    end
    // read bits stop after a master nack, or the stop would be blocked
    always @(negedge scl)
    begin
        if (n == 8)
        begin
            if (k < 3)
                got[k] = rx;
            if (k == 0)
                rd = rx[0];
            pull = (k == 0) ? (rx[7:1] == ADDR && !nak) : !rd;
        end
        else
        begin
            if (n == 9)
            begin
                n = 0;
                k = k + 1;
            end
            pull = rd && k > 0 && k < 3 && !(n == 0 && rx[0]) && !RDATA[23 - 8 * k - n];
        end
    end
endmodule
`default_nettype wire

// ===== logic/two_wire_master_engine.sv
// Notes on behaviour
// - master only, fast mode, bus clock at 400 kHz on every transfer.
// - bus clock follows the 400 kHz time-base reference, no local divider.
// - each frame carries one or two data bytes, read or write, fewer if a byte is refused.
// - address register: 7-bit slave address on top, bit 0 direction, 1 reads.
// - write sends first write byte, then second one if length bit set.
// - writing one to control bit 1 launches the transfer as loaded.
// - read stores first byte, then second byte if length bit set.
// - completion raises the request on external interrupt 6.
// - completion request stays until next launch, then drops by itself.
// - control bit 2 set on missing acknowledge, cleared on next launch.
// - start bit reads one while busy, clears itself when done.
`timescale 1ns/10ps
`default_nettype none
`include "two_wire_regs.svh"

module two_wire_master_engine
    import two_wire_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // time-base bus clock reference
    input  wire logic        bus_clock_ref,
    // special-function register port
    input  wire logic [15:0] sfr_addr,
    input  wire logic        sfr_write,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    // interrupt to external interrupt 6
    output logic             ext_irq6,
    // two-wire bus, open drain
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe
);

    engine_state_type state;

    logic [7:0] slave_address_direction;
    logic [7:0] first_write_byte;
    logic [7:0] second_write_byte;
    logic [7:0] first_read_byte;
    logic [7:0] second_read_byte;
    logic       two_byte_length_bit;
    logic       launch_busy_bit;
    logic       missing_ack_flag;
    logic       completion_irq_enable;
    logic       completion_irq_flag;
    logic       ref_prev;
    logic [3:0] bit_count;
    logic [1:0] byte_index;
    logic [7:0] rx_shift;

    // time-base edges; data moves on the falling edge, sampling on the rising
    wire ref_rise = bus_clock_ref & ~ref_prev;
    wire ref_fall = ~bus_clock_ref & ref_prev;

    wire write_slave_addr  = sfr_write && (sfr_addr == `ADDR_SLAVE_ADDRESS_DIRECTION);
    wire write_first_byte  = sfr_write && (sfr_addr == `ADDR_FIRST_WRITE_BYTE);
    wire write_second_byte = sfr_write && (sfr_addr == `ADDR_SECOND_WRITE_BYTE);
    wire write_control     = sfr_write && (sfr_addr == `ADDR_TRANSFER_CONTROL_STATUS);
    wire write_irq6        = sfr_write && (sfr_addr == `ADDR_EXT_IRQ6_CONTROL);

    wire launch = write_control && sfr_wdata[`LAUNCH_BUSY_BIT] && !launch_busy_bit;

    wire       read_dir   = slave_address_direction[`DIRECTION_BIT];
    wire       addr_phase = (byte_index == 2'd0);
    wire       tx_phase   = addr_phase || !read_dir;
    wire       last_byte  = (byte_index == (two_byte_length_bit ? 2'd2 : 2'd1));
    wire       ack_slot   = (bit_count == `ACK_SLOT);
    wire [2:0] bit_pos    = 3'd7 - bit_count[2:0];

    // byte on the wire: address first, then write data in order
    wire [7:0] tx_byte = addr_phase         ? slave_address_direction :
                         (byte_index == 2'd1) ? first_write_byte : second_write_byte;

    wire [7:0] control_view = {5'b0_0000, missing_ack_flag, launch_busy_bit, two_byte_length_bit};
    wire [7:0] irq6_view    = {4'h0, completion_irq_enable, completion_irq_flag, 2'b00};

    wire [7:0] next_rdata =
        (sfr_addr == `ADDR_SLAVE_ADDRESS_DIRECTION) ? slave_address_direction :
        (sfr_addr == `ADDR_FIRST_WRITE_BYTE)        ? first_write_byte :
        (sfr_addr == `ADDR_SECOND_WRITE_BYTE)       ? second_write_byte :
        (sfr_addr == `ADDR_FIRST_READ_BYTE)         ? first_read_byte :
        (sfr_addr == `ADDR_SECOND_READ_BYTE)        ? second_read_byte :
        (sfr_addr == `ADDR_TRANSFER_CONTROL_STATUS) ? control_view :
        (sfr_addr == `ADDR_EXT_IRQ6_CONTROL)        ? irq6_view : `RESET_BYTE;

    // software registers; no busy interlock on data, software holds off
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            slave_address_direction <= `RESET_BYTE;
            first_write_byte        <= `RESET_BYTE;
            second_write_byte       <= `RESET_BYTE;
            two_byte_length_bit     <= 1'b0;
            completion_irq_enable   <= 1'b0;
            sfr_rdata               <= `RESET_BYTE;
            ext_irq6                <= 1'b0;
        end
        else
        begin
            if (write_slave_addr)
                slave_address_direction <= sfr_wdata;
            if (write_first_byte)
                first_write_byte <= sfr_wdata;
            if (write_second_byte)
                second_write_byte <= sfr_wdata;
            // length is frozen while a frame runs
            if (write_control && !launch_busy_bit)
                two_byte_length_bit <= sfr_wdata[`TWO_BYTE_LENGTH_BIT];
            if (write_irq6)
                completion_irq_enable <= sfr_wdata[`COMPLETION_IRQ_ENABLE];
            sfr_rdata <= next_rdata;
            ext_irq6  <= completion_irq_flag && completion_irq_enable;
        end
    end

    // bus engine
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state               <= ST_IDLE;
            ref_prev            <= 1'b0;
            launch_busy_bit     <= 1'b0;
            missing_ack_flag    <= 1'b0;
            completion_irq_flag <= 1'b0;
            first_read_byte     <= `RESET_BYTE;
            second_read_byte    <= `RESET_BYTE;
            bit_count           <= 4'h0;
            byte_index          <= 2'd0;
            rx_shift            <= `RESET_BYTE;
            scl_oe              <= 1'b0;
            sda_oe              <= 1'b0;
            scl_out             <= 1'b0;
            sda_out             <= 1'b0;
        end
        else
        begin
            ref_prev <= bus_clock_ref;
            // open drain: the pins are only ever pulled low
            scl_out  <= 1'b0;
            sda_out  <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    scl_oe <= 1'b0;
                    sda_oe <= 1'b0;
                    if (launch)
                    begin
                        launch_busy_bit     <= 1'b1;
                        missing_ack_flag    <= 1'b0;
                        completion_irq_flag <= 1'b0;
                        byte_index          <= 2'd0;
                        bit_count           <= 4'h0;
                        state               <= ST_START_HIGH;
                    end
                end
                ST_START_HIGH:
                    if (ref_rise)
                        state <= ST_START_LOW;
                ST_START_LOW:
                    // data falls while the clock is high: start condition
                    if (ref_fall)
                    begin
                        sda_oe <= 1'b1;
                        state  <= ST_XFER;
                    end
                ST_XFER:
                begin
                    if (ref_fall)
                    begin
                        scl_oe <= 1'b1;
                        if (!ack_slot)
                            sda_oe <= tx_phase ? ~tx_byte[bit_pos] : 1'b0;
                        else
                            sda_oe <= tx_phase ? 1'b0 : !last_byte;
                    end
                    // only a rise after our own low phase counts as a bit
                    else if (ref_rise && scl_oe)
                    begin
                        scl_oe <= 1'b0;
                        if (!ack_slot)
                        begin
                            bit_count <= bit_count + 4'h1;
                            rx_shift  <= {rx_shift[6:0], sda_in};
                        end
                        else
                        begin
                            bit_count <= 4'h0;
                            if (!tx_phase && byte_index == 2'd1)
                                first_read_byte <= rx_shift;
                            if (!tx_phase && byte_index == 2'd2)
                                second_read_byte <= rx_shift;
                            // a refused byte ends the frame at once
                            if (tx_phase && sda_in)
                            begin
                                missing_ack_flag <= 1'b1;
                                state            <= ST_STOP_LOW;
                            end
                            else if (last_byte)
                                state <= ST_STOP_LOW;
                            else
                                byte_index <= byte_index + 2'd1;
                        end
                    end
                end
                ST_STOP_LOW:
                    if (ref_fall)
                    begin
                        scl_oe <= 1'b1;
                        sda_oe <= 1'b1;
                        state  <= ST_STOP_HIGH;
                    end
                ST_STOP_HIGH:
                    if (ref_rise)
                    begin
                        scl_oe <= 1'b0;
                        state  <= ST_STOP_RELEASE;
                    end
                ST_STOP_RELEASE:
                    if (ref_fall)
                    begin
                        sda_oe              <= 1'b0;
                        launch_busy_bit     <= 1'b0;
                        completion_irq_flag <= 1'b1;
                        state               <= ST_IDLE;
                    end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // no clock stretching, the bus clock is never read back
    wire unused_scl = scl_in;

endmodule

`default_nettype wire

// ===== logic/two_wire_pkg.sv
`default_nettype none
package two_wire_pkg;

    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_START_HIGH,
        ST_START_LOW,
        ST_XFER,
        ST_STOP_LOW,
        ST_STOP_HIGH,
        ST_STOP_RELEASE
    } engine_state_type;

endpackage
`default_nettype wire

// ===== logic/two_wire_regs.svh
`ifndef TWO_WIRE_REGS_SVH
`define TWO_WIRE_REGS_SVH

// special-function register addresses
`define ADDR_SLAVE_ADDRESS_DIRECTION 16'hff80
`define ADDR_FIRST_WRITE_BYTE        16'hff81
`define ADDR_SECOND_WRITE_BYTE       16'hff82
`define ADDR_FIRST_READ_BYTE         16'hff83
`define ADDR_SECOND_READ_BYTE        16'hff84
`define ADDR_TRANSFER_CONTROL_STATUS 16'hff85
`define ADDR_EXT_IRQ6_CONTROL        16'hff95

// field positions
`define DIRECTION_BIT        0
`define TWO_BYTE_LENGTH_BIT  0
`define LAUNCH_BUSY_BIT      1
`define MISSING_ACK_FLAG     2
`define COMPLETION_IRQ_FLAG  2
`define COMPLETION_IRQ_ENABLE 3

// reset values
`define RESET_BYTE 8'h00

// bit counter: eight data bits, then the acknowledge slot at this count
`define ACK_SLOT 4'h8

// bus clock rate delivered by the time base
`define BUS_CLOCK_KHZ 400

`endif
